// file: smi_ctrl.sv
// host sequencer driving the synth modulator register port over a write channel
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module smi_ctrl #(
    parameter int LOCK_CYC = smi_pkg::SMI_LOCK_CYC // lock wait, cycles
) (
    input  wire logic        clock,          // 10 MHz
    input  wire logic        rst_n,          // sync reset
    input  wire logic [3:0]  avs_address,    // byte address
    input  wire logic        avs_read,       // read strobe
    input  wire logic        avs_write,      // write strobe
    input  wire logic [31:0] avs_writedata,  // write data
    output logic      [31:0] avs_readdata,   // read data
    output logic             avs_waitrequest,// stall
    output logic             dev_wr_valid,   // register write request
    input  wire logic        dev_wr_ready,   // write accepted by port
    output logic      [5:0]  dev_wr_index,   // device register index
    output logic      [7:0]  dev_wr_data,    // device register value
    input  wire logic        lock_indicator  // pll lock pin
);
    import smi_pkg::*;

    smi_state_t  state_q;
    logic        retune_q;      // running retune, not init
    logic [5:0]  step_q;
    logic [31:0] tune_q;        // [31:24] fine low, [23:16] fine mid, [15:8] fine hi/int
    logic [31:0] ref_q;         // [7:0] ref ctrl, [15:8] ref div, [18:16] divsel,
                                // [19] band, [27:20] int low, [28] fine top bit, [29] int hi
    logic [7:0]  ctrl_q;
    logic        timeout_q;
    logic        tout_seen_q;   // last lock wait ended by timeout
    logic        rd_ack_q;      // read data loaded, answer this cycle
    logic [31:0] lock_cnt_q;
    logic        lk_s1_q, lk_s2_q, lk_s3_q, lock_q;
    logic        busy_q;
    logic        done_q;
    logic [5:0]  idx;
    logic [7:0]  val;

    // lock pin synchroniser, change accepted once stages two and three agree
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lk_s1_q <= 1'b0;
            lk_s2_q <= 1'b0;
            lk_s3_q <= 1'b0;
            lock_q  <= 1'b0;
        end else begin
            lk_s1_q <= lock_indicator;
            lk_s2_q <= lk_s1_q;
            lk_s3_q <= lk_s2_q;
            if (lk_s2_q == lk_s3_q) lock_q <= lk_s3_q; // RULE23
        end
    end

    // step table: init writes 30 down to 0 in descending index, then lo range and modulator power, never 31..33 (RULE2)
    function automatic logic [13:0] init_step(input logic [5:0] s, input logic [31:0] r,
                                              input logic [31:0] t);
        logic [7:0] lr;
        lr = {3'h0, r[19], 4'h0};                                // RULE7
        unique case (s)
            6'd0:  init_step = {SMI_IDX_ATTEN, SMI_V_ATTEN};     // RULE3
            6'd1:  init_step = {SMI_IDX_MODPWR, SMI_V_MODOFF};   // RULE4
            6'd2:  init_step = {SMI_IDX_DIVSEL, SMI_V_DIVSEL | {5'h0, r[18:16]}}; // RULE6
            6'd3:  init_step = {SMI_IDX_LORNG, lr};
            6'd4:  init_step = {6'd26, SMI_V_R00};               // RULE11
            6'd5:  init_step = {6'd25, SMI_V_ACTIMER};           // RULE8
            6'd6:  init_step = {6'd24, SMI_V_ACCTRL};            // RULE9
            6'd7:  init_step = {6'd23, SMI_V_LD1};               // RULE10
            6'd8:  init_step = {6'd22, SMI_V_R80};
            6'd9:  init_step = {6'd21, SMI_V_R00};
            6'd10: init_step = {6'd20, SMI_V_R00};
            6'd11: init_step = {6'd19, SMI_V_R80};
            6'd12: init_step = {6'd18, SMI_V_R00};
            6'd13: init_step = {6'd17, SMI_V_R00};
            6'd14: init_step = {6'd16, SMI_V_R00};
            6'd15: init_step = {6'd15, SMI_V_R00};
            6'd16: init_step = {6'd14, SMI_V_LOGATE};            // RULE12
            6'd17: init_step = {6'd13, SMI_V_LD2};               // RULE10
            6'd18: init_step = {6'd12, SMI_V_PLLPWR};            // RULE13
            6'd19: init_step = {6'd11, SMI_V_R00};
            6'd20: init_step = {6'd10, r[7:0]};
            6'd21: init_step = {6'd9,  SMI_V_CP};                // RULE14
            6'd22: init_step = {6'd8,  SMI_V_R00};
            6'd23: init_step = {6'd7,  SMI_V_WHMUX | {7'h0, r[29]}}; // RULE15
            6'd24: init_step = {6'd6,  r[27:20]};
            6'd25: init_step = {6'd5,  r[15:8]};
            6'd26: init_step = {6'd4,  SMI_V_R01};
            6'd27: init_step = {6'd3,  SMI_V_FTOP | {7'h0, r[28]}};  // RULE16
            6'd28: init_step = {6'd2,  t[15:8]};
            6'd29: init_step = {6'd1,  t[23:16]};
            6'd30: init_step = {SMI_IDX_COMMIT, t[31:24]};       // RULE17
            6'd31: init_step = {SMI_IDX_LORNG, lr};              // RULE18
            default: init_step = {SMI_IDX_MODPWR, SMI_V_MODON};
        endcase
    endfunction

    // retune: buffered values, commit, then lo range last
    function automatic logic [13:0] tune_step(input logic [5:0] s, input logic [31:0] r,
                                              input logic [31:0] t);
        unique case (s)
            6'd0: tune_step = {SMI_IDX_DIVSEL, SMI_V_DIVSEL | {5'h0, r[18:16]}};
            6'd1: tune_step = {6'd7, SMI_V_WHMUX | {7'h0, r[29]}};
            6'd2: tune_step = {6'd6, r[27:20]};
            6'd3: tune_step = {6'd3, SMI_V_FTOP | {7'h0, r[28]}};
            6'd4: tune_step = {6'd2, t[15:8]};
            6'd5: tune_step = {6'd1, t[23:16]};
            6'd6: tune_step = {SMI_IDX_COMMIT, t[31:24]};
            default: tune_step = {SMI_IDX_LORNG, {3'h0, r[19], 4'h0}}; // RULE22
        endcase
    endfunction

    // current step decode
    always_comb begin
        if (retune_q) {idx, val} = tune_step(step_q, ref_q, tune_q);
        else          {idx, val} = init_step(step_q, ref_q, tune_q);
    end

    // avalon slave: writes take no wait state; a read waits one cycle so the
    // registered read data already stands when waitrequest drops
    assign avs_waitrequest = avs_read && !rd_ack_q;
    always_ff @(posedge clock) begin
        if (!rst_n) rd_ack_q <= 1'b0;
        else        rd_ack_q <= avs_read && !rd_ack_q;
    end
    // unmapped reads give zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_q <= SMI_V_CTRL_RST;
            tune_q <= '0;
            ref_q  <= '0;
        end else if (avs_write) begin
            unique case (avs_address)
                SMI_OFS_CTRL: ctrl_q <= avs_writedata[7:0];
                SMI_OFS_TUNE: tune_q <= avs_writedata;
                SMI_OFS_REF:  ref_q  <= avs_writedata;
                default: ;
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) avs_readdata <= '0;
        else if (avs_read && !rd_ack_q) begin
            unique case (avs_address)
                SMI_OFS_CTRL:   avs_readdata <= {24'h0, ctrl_q};
                SMI_OFS_STATUS: avs_readdata <= {26'h0, step_q == 6'd0, tout_seen_q,
                                                 lock_q, done_q, busy_q, retune_q};
                SMI_OFS_TUNE:   avs_readdata <= tune_q;
                SMI_OFS_REF:    avs_readdata <= ref_q;
                default:        avs_readdata <= '0;
            endcase
        end
    end

    // start pulses: ctrl bit0 = init, bit1 = retune (write pulses)
    logic go_init, go_tune;
    assign go_init = avs_write && avs_address == SMI_OFS_CTRL && avs_writedata[0];
    assign go_tune = avs_write && avs_address == SMI_OFS_CTRL && avs_writedata[1];

    // sequencer: one write per step, handshake with the port
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q  <= SMI_IDLE;
            step_q   <= 6'd0;
            retune_q <= 1'b0;
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            unique case (state_q)
                SMI_IDLE: if (go_init || go_tune) begin // RULE1
                    state_q  <= SMI_SEND;
                    step_q   <= 6'd0;
                    retune_q <= go_tune && !go_init;
                    busy_q   <= 1'b1;
                    done_q   <= 1'b0;
                end
                SMI_SEND: if (dev_wr_ready) begin
                    if (retune_q && step_q == SMI_TUNE_LEN - 6'd3) begin
                        state_q <= SMI_IDLE;
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                    end else if (!retune_q && step_q == SMI_INIT_LEN - 6'd2) begin
                        state_q <= SMI_LOCK; // RULE5
                    end else begin
                        step_q <= step_q + 6'd1;
                    end
                end
                SMI_LOCK: if (lock_q || timeout_q) begin // RULE19 RULE25
                    state_q <= SMI_MODW;
                    step_q  <= step_q + 6'd1;
                end
                SMI_MODW: if (dev_wr_ready) begin // RULE20
                    state_q <= SMI_IDLE;
                    busy_q  <= 1'b0;
                    done_q  <= 1'b1;
                end
                default: state_q <= SMI_IDLE;
            endcase
        end
    end

    // own lock timeout counter
    always_ff @(posedge clock) begin
        if (!rst_n || state_q != SMI_LOCK) begin
            lock_cnt_q <= '0;
            timeout_q  <= 1'b0;
        end else begin
            lock_cnt_q <= lock_cnt_q + 32'd1;
            if (lock_cnt_q >= 32'(LOCK_CYC - 1)) timeout_q <= 1'b1; // RULE25
        end
    end

    // sticky timeout report for software; timeout_q lasts too briefly to read
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tout_seen_q <= 1'b0;
        end else if (timeout_q) begin
            tout_seen_q <= 1'b1; // set wins over a clear
        end else if (state_q == SMI_IDLE && (go_init || go_tune)) begin
            tout_seen_q <= 1'b0;
        end
    end

    assign dev_wr_valid = state_q == SMI_SEND || state_q == SMI_MODW;
    assign dev_wr_index = idx;
    assign dev_wr_data  = val;

    // lock wait must end by the timeout; counted, since the wait is too long for a range
    property p_lock_bound;
        @(posedge clock) disable iff (!rst_n)
        state_q == SMI_LOCK |-> lock_cnt_q <= 32'(LOCK_CYC);
    endproperty
    a_lock_bound: assert property (p_lock_bound) else $error("lock wait overran"); // RULE19
    property p_modon_after;
        @(posedge clock) disable iff (!rst_n)
        dev_wr_valid && dev_wr_data == SMI_V_MODON && dev_wr_index == SMI_IDX_MODPWR
            |-> state_q == SMI_MODW;
    endproperty
    a_modon_after: assert property (p_modon_after) else $error("modulator on too early"); // RULE5
    property p_no_ro;
        @(posedge clock) disable iff (!rst_n) dev_wr_valid |-> dev_wr_index < 6'd31;
    endproperty
    a_no_ro: assert property (p_no_ro) else $error("read-only register written"); // RULE2
    property p_first;
        @(posedge clock) disable iff (!rst_n)
        $rose(busy_q) && !retune_q |-> dev_wr_index == SMI_IDX_ATTEN && dev_wr_data == 8'h00;
    endproperty
    a_first: assert property (p_first) else $error("first write not attenuator"); // RULE3
    property p_lock_go;
        @(posedge clock) disable iff (!rst_n)
        state_q == SMI_LOCK && lock_q |=> state_q == SMI_MODW;
    endproperty
    a_lock_go: assert property (p_lock_go) else $error("lock not taken"); // RULE25
    property p_divsel;
        @(posedge clock) disable iff (!rst_n)
        dev_wr_valid && dev_wr_index == SMI_IDX_DIVSEL |-> dev_wr_data[7:3] == 5'b00001;
    endproperty
    a_divsel: assert property (p_divsel) else $error("divider select bit 3"); // RULE6
    property p_lorng;
        @(posedge clock) disable iff (!rst_n)
        dev_wr_valid && dev_wr_index == SMI_IDX_LORNG |-> (dev_wr_data & 8'hef) == 8'h00;
    endproperty
    a_lorng: assert property (p_lorng) else $error("lo range stray bits"); // RULE7
    property p_commit_then_lr;
        @(posedge clock) disable iff (!rst_n)
        dev_wr_valid && dev_wr_ready && dev_wr_index == SMI_IDX_COMMIT
            |=> dev_wr_valid && dev_wr_index == SMI_IDX_LORNG;
    endproperty
    a_commit_then_lr: assert property (p_commit_then_lr) else $error("lo range not after commit"); // RULE22
    // a stalled write request must not move
    property p_wr_hold;
        @(posedge clock) disable iff (!rst_n)
        dev_wr_valid && !dev_wr_ready
            |=> dev_wr_valid && $stable(dev_wr_index) && $stable(dev_wr_data);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write request moved while stalled"); // RULE17
    // modulator stays off for every write sent before the lock wait
    property p_modoff;
        @(posedge clock) disable iff (!rst_n)
        dev_wr_valid && state_q == SMI_SEND && dev_wr_index == SMI_IDX_MODPWR
            |-> dev_wr_data == SMI_V_MODOFF;
    endproperty
    a_modoff: assert property (p_modoff) else $error("modulator power not held off"); // RULE4
    // a held read is answered one cycle later
    property p_rd_answer;
        @(posedge clock) disable iff (!rst_n)
        avs_read && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered"); // RULE1
    c_lock:  cover property (@(posedge clock) state_q == SMI_LOCK && lock_q);
    c_init:  cover property (@(posedge clock) state_q == SMI_MODW && dev_wr_ready);
    c_tout:  cover property (@(posedge clock) timeout_q && !lock_q);
    c_tune:  cover property (@(posedge clock) retune_q && done_q);
endmodule // smi_ctrl
`default_nettype wire

// file: smi_pkg.sv
// package: register indices, fixed values and timing for the synth init sequencer
// What this block does, and what it relies on the device doing
// (RULE1) write every writable device register at start
// (RULE2) never write the three read-only registers
// (RULE3) attenuator 0x00 first, then descending indices
// (RULE4) modulator power 0x80 keeps modulator off
// (RULE5) modulator on only after pll lock; the block also turns it on after its own lock timeout
// (RULE6) divider select: code low bits, bit3 set
// (RULE7) lo range: only bit 4 by band
// (RULE8) autocal timer 0x64 for 40 MHz pfd
// (RULE9) autocal control gets 0x18
// (RULE10) lock detect controls get 0x70 and 0xe8
// (RULE11) reserved registers get their fixed values
// (RULE12) lo gating register gets 0x80
// (RULE13) pll power register gets 0x18
// (RULE14) charge pump register gets 0xf0
// (RULE15) whole part high/low, monitor output tristate
// (RULE16) fine top 0000010x, then lower fine registers
// (RULE17) commit register is last buffered write
// (RULE18) lo range rewritten after commit in init
// (RULE19) lock indicator high or 170 us wait
// (RULE20) modulator power 0x81 needs no commit
// (RULE21) device reloads buffered values on commit
// (RULE22) retune ends with commit then lo range
// (RULE23) device lock indicator tracks pll lock
// (RULE24) device disables rf while transmit disable high
// (RULE25) proceed on lock or own timeout count
package smi_pkg;
    // avalon register offsets (byte addresses)
    localparam logic [3:0] SMI_OFS_CTRL   = 4'h0;
    localparam logic [3:0] SMI_OFS_STATUS = 4'h4;
    localparam logic [3:0] SMI_OFS_TUNE   = 4'h8;
    localparam logic [3:0] SMI_OFS_REF    = 4'hc;
    // device register indices
    localparam logic [5:0] SMI_IDX_ATTEN  = 6'h1e;
    localparam logic [5:0] SMI_IDX_MODPWR = 6'h1d;
    localparam logic [5:0] SMI_IDX_DIVSEL = 6'h1c;
    localparam logic [5:0] SMI_IDX_LORNG  = 6'h1b;
    localparam logic [5:0] SMI_IDX_COMMIT = 6'h00;
    // fixed values
    localparam logic [7:0] SMI_V_ATTEN    = 8'h00;
    localparam logic [7:0] SMI_V_MODOFF   = 8'h80;
    localparam logic [7:0] SMI_V_MODON    = 8'h81;
    localparam logic [7:0] SMI_V_DIVSEL   = 8'h08;
    localparam logic [7:0] SMI_V_ACTIMER  = 8'h64;
    localparam logic [7:0] SMI_V_ACCTRL   = 8'h18;
    localparam logic [7:0] SMI_V_LD1      = 8'h70;
    localparam logic [7:0] SMI_V_LD2      = 8'he8;
    localparam logic [7:0] SMI_V_LOGATE   = 8'h80;
    localparam logic [7:0] SMI_V_PLLPWR   = 8'h18;
    localparam logic [7:0] SMI_V_CP       = 8'hf0;
    localparam logic [7:0] SMI_V_R80      = 8'h80;
    localparam logic [7:0] SMI_V_R01      = 8'h01;
    localparam logic [7:0] SMI_V_R00      = 8'h00;
    localparam logic [7:0] SMI_V_FTOP     = 8'h04;
    localparam logic [7:0] SMI_V_WHMUX    = 8'h00; // monitor output tristate code
    localparam logic [7:0] SMI_V_CTRL_RST = 8'h00;
    // lock timeout
    localparam int         SMI_CLK_HZ     = 10_000_000;
    localparam int         SMI_LOCK_US    = 170;
    localparam int         SMI_LOCK_CYC   = (SMI_LOCK_US * (SMI_CLK_HZ / 1000)) / 1000;
    // sequence lengths
    localparam logic [5:0] SMI_INIT_LEN   = 6'd33;
    localparam logic [5:0] SMI_TUNE_LEN   = 6'd10;
    typedef enum logic [4:0] {
        SMI_IDLE = 5'b00001,
        SMI_SEND = 5'b00010,
        SMI_WAIT = 5'b00100,
        SMI_LOCK = 5'b01000,
        SMI_MODW = 5'b10000
    } smi_state_t;
endpackage : smi_pkg

// file: smi_dev_model.sv
// behavioural synth modulator register port with lock indicator
`timescale 1ns/100ps
`default_nettype none
module smi_dev_model #(
    parameter int LOCK_DLY = 6 // commit to lock, cycles
) (
    input  wire logic       clock,      // host clock
    input  wire logic       rst_n,      // sync reset
    input  wire logic       wr_valid,   // write request
    output logic            wr_ready,   // write taken
    input  wire logic [5:0] wr_index,   // register index
    input  wire logic [7:0] wr_data,    // register value
    input  wire logic       allow_lock, // pll may lock
    input  wire logic       stall_en,   // random stalls
    input  wire logic       tx_disable, // transmit disable input
    output logic            lock_pin,   // lock indicator
    output logic            lo_stopped, // lo clock halted
    output logic            mod_on      // modulator powered
);
    logic [7:0] shadow_q [0:33]; // as written
    logic [7:0] live_q   [0:33]; // in effect
    int         acq_q;           // acquisition countdown
    logic       stall_q;         // slow answer
    logic       take;            // write accepted
    assign take = wr_valid && wr_ready;
    assign wr_ready = !stall_q;
    // stalls test that requests hold steady
    always_ff @(posedge clock) begin
        stall_q <= rst_n && stall_en && ($urandom % 3 == 0);
    end
    // buffered values wait for commit; modulator power and lo gating act at once
    always_ff @(posedge clock) begin
        if (take) begin
            shadow_q[wr_index] <= wr_data;
            if (wr_index == 6'h00) begin
                live_q <= shadow_q;
                live_q[0] <= wr_data;
            end else if (wr_index == 6'h1d || wr_index == 6'h0e) begin
                live_q[wr_index] <= wr_data;
            end
        end
    end
    // commit restarts acquisition; lock shows after a delay if allowed
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acq_q <= 0;
            lock_pin <= 1'b0;
        end else if (take && wr_index == 6'h00) begin
            acq_q <= LOCK_DLY;
            lock_pin <= 1'b0;
        end else if (acq_q > 0) begin
            acq_q <= acq_q - 1;
            lock_pin <= (acq_q == 1) && allow_lock;
        end
    end
    assign lo_stopped = tx_disable && live_q[14][7];
    assign mod_on = live_q[29][0];
endmodule // smi_dev_model
`default_nettype wire

// file: smi_ctrl_bench.sv
// self-checking bench for the synth init sequencer
`timescale 1ns/100ps
`default_nettype none
module smi_ctrl_bench;
    import smi_pkg::*;
    localparam int LCYC = 20; // shortened lock wait
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        avs_read, avs_write, avs_waitrequest, dev_wr_valid, dev_wr_ready, lock_pin;
    logic        allow_lock, stall_en, tx_dis, lo_stopped, mod_on;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, tn, rf;
    logic [5:0]  dev_wr_index;
    logic [7:0]  dev_wr_data;
    logic [13:0] seen [$];
    int          fails, checked, cyc, t27, gap;
    smi_ctrl #(.LOCK_CYC(LCYC)) dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dev_wr_valid(dev_wr_valid), .dev_wr_ready(dev_wr_ready),
        .dev_wr_index(dev_wr_index), .dev_wr_data(dev_wr_data), .lock_indicator(lock_pin));
    smi_dev_model model (.clock(clock), .rst_n(rst_n), .wr_valid(dev_wr_valid),
        .wr_ready(dev_wr_ready), .wr_index(dev_wr_index), .wr_data(dev_wr_data),
        .allow_lock(allow_lock), .stall_en(stall_en), .tx_disable(tx_dis),
        .lock_pin(lock_pin), .lo_stopped(lo_stopped), .mod_on(mod_on));
    initial forever #50 clock = ~clock;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // write log, lock wait span, cycle ceiling last
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (rst_n && dev_wr_valid === 1'b1 && dev_wr_ready === 1'b1) begin
            seen.push_back({dev_wr_index, dev_wr_data});
            chk(dev_wr_index < 6'h1f, 1);
            if (dev_wr_index == 6'h1b) t27 = cyc;
            if (dev_wr_index == 6'h1d && dev_wr_data == 8'h81) gap = cyc - t27;
        end
        if (cyc > 20000) begin
            fails = fails + 1;
            close_out();
        end
    end
    // request held until waitrequest is seen low; read data taken at that edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rst();
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
    endtask
    function automatic logic [7:0] val(input logic [5:0] i);
        case (i)
            6'h1d, 6'h16, 6'h13, 6'h0e: return 8'h80;
            6'h1c: return {5'b00001, rf[18:16]};
            6'h1b: return {3'b000, rf[19], 4'h0};
            6'h19: return 8'h64;
            6'h18, 6'h0c: return 8'h18;
            6'h17: return 8'h70;
            6'h0d: return 8'he8;
            6'h0a: return rf[7:0];
            6'h09: return 8'hf0;
            6'h07: return {7'h00, rf[29]};
            6'h06: return rf[27:20];
            6'h05: return rf[15:8];
            6'h04: return 8'h01;
            6'h03: return {7'b0000010, rf[28]};
            6'h02: return tn[15:8];
            6'h01: return tn[23:16];
            6'h00: return tn[31:24];
            default: return 8'h00;
        endcase
    endfunction
    // one init or retune run with random words; a second start while busy must be ignored
    task automatic go(input logic [1:0] cmd);
        logic [13:0] exp [$];
        logic [5:0]  rt [8] = '{6'h1c, 6'h07, 6'h06, 6'h03, 6'h02, 6'h01, 6'h00, 6'h1b};
        seen.delete();
        tn = $urandom;
        rf = $urandom;
        bus(1'b1, SMI_OFS_TUNE, tn);
        bus(1'b1, SMI_OFS_REF, rf);
        bus(1'b1, SMI_OFS_CTRL, {30'h0, cmd});
        bus(1'b1, SMI_OFS_CTRL, 32'h3);
        if (cmd[0]) begin
            for (int i = 30; i >= 0; i--) exp.push_back({i[5:0], val(i[5:0])});
            exp.push_back({6'h1b, val(6'h1b)});
            exp.push_back({6'h1d, 8'h81});
        end else begin
            foreach (rt[i]) exp.push_back({rt[i], val(rt[i])});
        end
        while (seen.size() < exp.size()) @(posedge clock);
        repeat (30) @(posedge clock);
        chk(seen.size(), exp.size());
        foreach (exp[i]) chk(seen[i], exp[i]);
        bus(1'b0, SMI_OFS_STATUS, 32'h0);
        chk(rd[2:1], 2'b10); // done and idle
        $display("test cmd=%0d over", cmd);
    endtask
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {allow_lock, stall_en, tx_dis} = 3'b111;
        {fails, checked, cyc, t27, gap} = '0;
        rd = $urandom(62857);
        rst();
        chk(dev_wr_valid, 0); // idle after reset
        bus(1'b1, 4'h2, 32'h1);
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 0); // unmapped read
        chk(seen.size(), 0); // unmapped write starts nothing
        go(2'b01);
        chk(gap < LCYC, 1);
        chk(rd[4], 0);
        chk({mod_on, lo_stopped}, 2'b11);
        tx_dis <= 1'b0;
        repeat (3) begin
            go(2'b10);
            chk(model.live_q[6], rf[27:20]);
        end
        chk(lo_stopped, 0);
        allow_lock <= 1'b0;
        rst();
        go(2'b01);
        chk(gap >= LCYC, 1);
        bus(1'b0, SMI_OFS_STATUS, 32'h0);
        chk(rd[4], 1);
        close_out();
    end
endmodule // smi_ctrl_bench
`default_nettype wire
